// ---- cps_top.sv ----
// Serial configuration target with register bank and nonvolatile store.
// Assumes SCL and SDA are open-drain pins sampled by link_clk_in, which
// runs several times faster than SCL; the bank lives on clk_in.
`timescale 1ns/1ps
module cps_top
    import cps_pkg::*;
#(
    parameter logic [7:0] LEADING_ID = CPS_ID_DEFAULT
) (
    // Core clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link sampling clock
    input wire logic link_clk_in,
    // Serial pins, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Status
    output logic nvm_busy_out
);

    cps_link_t l_q;
    cps_link_t l_d;
    cps_core_t c_q;
    cps_core_t c_d;

    logic scl_s2;
    logic scl_s3;
    logic sda_s2;
    logic sda_s3;
    logic ack_s;
    logic busy_s;
    logic req_s;

    logic scl_n;
    logic sda_n;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic pend;
    logic busy;

    logic reg_we;
    logic [7:0] reg_wa;
    logic [7:0] reg_wd;
    logic nvm_we;
    logic [7:0] rd_addr;
    logic [7:0] reg_rdata;
    logic [7:0] nvm_rdata;
    logic new_req;

    // Pin synchronisers, three stages each
    cps_sync #(.STAGES(CPS_PIN_STAGES)) u_scl_sync (
        .clk_in(link_clk_in),
        .reset_in(reset_in),
        .d_in(scl_in),
        .q_out(scl_s3),
        .prev_out(scl_s2)
    );

    cps_sync #(.STAGES(CPS_PIN_STAGES)) u_sda_sync (
        .clk_in(link_clk_in),
        .reset_in(reset_in),
        .d_in(sda_in),
        .q_out(sda_s3),
        .prev_out(sda_s2)
    );

    // Handshake toggles and busy level between domains
    cps_sync #(.STAGES(CPS_HS_STAGES)) u_ack_sync (
        .clk_in(link_clk_in),
        .reset_in(reset_in),
        .d_in(c_q.ack_tgl),
        .q_out(ack_s),
        .prev_out()
    );

    cps_sync #(.STAGES(CPS_HS_STAGES)) u_busy_sync (
        .clk_in(link_clk_in),
        .reset_in(reset_in),
        .d_in(c_q.busy),
        .q_out(busy_s),
        .prev_out()
    );

    cps_sync #(.STAGES(CPS_HS_STAGES)) u_req_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .d_in(l_q.req_tgl),
        .q_out(req_s),
        .prev_out()
    );

    // Link side: bit engine and byte sequencing
    always_comb begin
        l_d = l_q;
        // A pin change counts once the last two stages agree
        scl_n = (scl_s2 == scl_s3) ? scl_s3 : l_q.scl_f;
        sda_n = (sda_s2 == sda_s3) ? sda_s3 : l_q.sda_f;
        l_d.scl_f = scl_n;
        l_d.sda_f = sda_n;
        rise = !l_q.scl_f && scl_n;
        fall = l_q.scl_f && !scl_n;
        start = l_q.scl_f && scl_n && l_q.sda_f && !sda_n;
        stop = l_q.scl_f && scl_n && !l_q.sda_f && sda_n;
        pend = l_q.req_tgl != ack_s;
        // An outstanding request also hides the device until the core answers
        busy = pend || busy_s;

        // Read data is held by the core until its next answer
        if (ack_s != l_q.ack_old) begin
            l_d.ack_old = ack_s;
            if (l_q.req.op == CPS_OP_READ) begin
                l_d.rbuf = c_q.rdata;
            end
        end

        if (start) begin
            // Pointer survives a repeated start
            l_d.st = CPS_LS_RX;
            l_d.ph = CPS_PH_ADDR;
            l_d.bitc = 4'h0;
            l_d.oe = 1'b0;
            l_d.nvm_pend = 1'b0;
        end else if (stop) begin
            if (l_q.nvm_pend && !pend) begin
                l_d.req.op = l_q.nvm_save ? CPS_OP_SAVE : CPS_OP_RESTORE;
                l_d.req.addr = 8'h00;
                l_d.req.data = 8'h00;
                l_d.req_tgl = !l_q.req_tgl;
            end
            l_d.st = CPS_LS_IDLE;
            l_d.oe = 1'b0;
            l_d.nvm_pend = 1'b0;
        end else begin
            case (l_q.st)
                CPS_LS_RX: begin
                    if (rise && l_q.bitc < CPS_BITS_PER_BYTE) begin
                        l_d.sh = {l_q.sh[6:0], sda_n};
                        l_d.bitc = l_q.bitc + 4'h1;
                    end else if (fall && l_q.bitc == CPS_BITS_PER_BYTE) begin
                        l_d.bitc = 4'h0;
                        case (l_q.ph)
                            CPS_PH_ADDR: begin
                                if (l_q.sh[7:1] == CPS_TARGET_ADDR && !busy) begin
                                    l_d.oe = 1'b1;
                                    l_d.rd = l_q.sh[0];
                                    l_d.st = CPS_LS_ACK;
                                    l_d.ph = CPS_PH_CMD;
                                end else begin
                                    l_d.st = CPS_LS_IDLE;
                                end
                            end
                            CPS_PH_CMD: begin
                                l_d.oe = 1'b1;
                                l_d.st = CPS_LS_ACK;
                                l_d.ph = CPS_PH_XTRA;
                                // Upper six command bits are don't-care
                                case (l_q.sh[1:0])
                                    CPS_CMD_WRITE: begin
                                        l_d.ph = CPS_PH_REG;
                                    end
                                    CPS_CMD_SAVE: begin
                                        l_d.nvm_pend = 1'b1;
                                        l_d.nvm_save = 1'b1;
                                    end
                                    CPS_CMD_RESTORE: begin
                                        l_d.nvm_pend = 1'b1;
                                        l_d.nvm_save = 1'b0;
                                    end
                                    default: begin
                                        l_d.nvm_pend = 1'b0;
                                    end
                                endcase
                            end
                            CPS_PH_REG: begin
                                l_d.ptr = l_q.sh;
                                l_d.oe = 1'b1;
                                l_d.st = CPS_LS_ACK;
                                l_d.ph = CPS_PH_DATA;
                            end
                            CPS_PH_DATA: begin
                                // Core answers long before the next byte ends
                                if (!pend) begin
                                    l_d.req.op = CPS_OP_WRITE;
                                    l_d.req.addr = l_q.ptr;
                                    l_d.req.data = l_q.sh;
                                    l_d.req_tgl = !l_q.req_tgl;
                                end
                                l_d.ptr = l_q.ptr + 8'h01;
                                l_d.oe = 1'b1;
                                l_d.st = CPS_LS_ACK;
                            end
                            default: begin
                                // Extra byte after save or restore: refuse it
                                l_d.st = CPS_LS_IDLE;
                                l_d.nvm_pend = 1'b0;
                            end
                        endcase
                    end
                end
                CPS_LS_ACK: begin
                    if (fall) begin
                        l_d.bitc = 4'h0;
                        if (l_q.rd) begin
                            l_d.txb = LEADING_ID;
                            l_d.oe = !LEADING_ID[7];
                            l_d.st = CPS_LS_TX;
                            if (!pend) begin
                                l_d.req.op = CPS_OP_READ;
                                l_d.req.addr = l_q.ptr;
                                l_d.req.data = 8'h00;
                                l_d.req_tgl = !l_q.req_tgl;
                            end
                        end else begin
                            l_d.oe = 1'b0;
                            l_d.st = CPS_LS_RX;
                        end
                    end
                end
                CPS_LS_TX: begin
                    if (rise) begin
                        l_d.bitc = l_q.bitc + 4'h1;
                    end else if (fall) begin
                        if (l_q.bitc == CPS_BITS_PER_BYTE) begin
                            l_d.oe = 1'b0;
                            l_d.st = CPS_LS_TXACK;
                        end else begin
                            l_d.txb = {l_q.txb[6:0], 1'b0};
                            l_d.oe = !l_q.txb[6];
                        end
                    end
                end
                CPS_LS_TXACK: begin
                    if (rise) begin
                        // Controller NACK ends the read
                        l_d.st = sda_n ? CPS_LS_IDLE : CPS_LS_TXNEXT;
                    end
                end
                CPS_LS_TXNEXT: begin
                    if (fall) begin
                        l_d.txb = l_q.rbuf;
                        l_d.oe = !l_q.rbuf[7];
                        l_d.bitc = 4'h0;
                        l_d.ptr = l_q.ptr + 8'h01;
                        l_d.st = CPS_LS_TX;
                        // Prefetch the following register during this byte
                        if (!pend) begin
                            l_d.req.op = CPS_OP_READ;
                            l_d.req.addr = l_q.ptr + 8'h01;
                            l_d.req.data = 8'h00;
                            l_d.req_tgl = !l_q.req_tgl;
                        end
                    end
                end
                default: begin
                    l_d.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_in or posedge reset_in) begin
        if (reset_in) begin
            l_q <= '{scl_f: 1'b1, sda_f: 1'b1, st: CPS_LS_IDLE, ph: CPS_PH_ADDR,
                     req: '{op: CPS_OP_WRITE, addr: 8'h00, data: 8'h00},
                     default: '0};
        end else begin
            l_q <= l_d;
        end
    end

    // Core side: register bank and nonvolatile copy engine
    always_comb begin
        c_d = c_q;
        reg_we = 1'b0;
        nvm_we = 1'b0;
        reg_wa = c_q.idx;
        reg_wd = nvm_rdata;
        rd_addr = c_q.idx;
        // Request word is held stable until the answer toggle returns
        new_req = req_s != c_q.req_old;
        case (c_q.st)
            CPS_CS_IDLE: begin
                if (new_req) begin
                    c_d.req_old = req_s;
                    case (l_q.req.op)
                        CPS_OP_WRITE: begin
                            reg_we = 1'b1;
                            reg_wa = l_q.req.addr;
                            reg_wd = l_q.req.data;
                            c_d.ack_tgl = !c_q.ack_tgl;
                        end
                        CPS_OP_READ: begin
                            rd_addr = l_q.req.addr;
                            c_d.st = CPS_CS_READ;
                        end
                        default: begin
                            c_d.st = CPS_CS_COPY;
                            c_d.save = l_q.req.op == CPS_OP_SAVE;
                            c_d.idx = 8'h00;
                            c_d.half = 1'b0;
                            c_d.busy = 1'b1;
                            c_d.from_req = 1'b1;
                        end
                    endcase
                end
            end
            CPS_CS_READ: begin
                c_d.rdata = reg_rdata;
                c_d.ack_tgl = !c_q.ack_tgl;
                c_d.st = CPS_CS_IDLE;
            end
            CPS_CS_COPY: begin
                if (!c_q.half) begin
                    c_d.half = 1'b1;
                end else begin
                    c_d.half = 1'b0;
                    nvm_we = c_q.save;
                    reg_we = !c_q.save;
                    c_d.idx = c_q.idx + 8'h01;
                    if (c_q.idx == CPS_LAST_INDEX) begin
                        c_d.st = CPS_CS_IDLE;
                        c_d.busy = 1'b0;
                        c_d.from_req = 1'b0;
                        if (c_q.from_req) begin
                            c_d.ack_tgl = !c_q.ack_tgl;
                        end
                    end
                end
            end
            default: begin
                c_d.st = CPS_CS_IDLE;
            end
        endcase
    end

    // Reset enters a full restore, so the bank is loaded before any access
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            c_q <= '{st: CPS_CS_COPY, busy: 1'b1, default: '0};
        end else begin
            c_q <= c_d;
        end
    end

    cps_mem #(.AW(CPS_AW), .DW(CPS_DW)) u_regs (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .we_in(reg_we),
        .waddr_in(reg_wa),
        .wdata_in(reg_wd),
        .raddr_in(rd_addr),
        .rdata_out(reg_rdata)
    );

    cps_mem #(.AW(CPS_AW), .DW(CPS_DW)) u_nvm (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .we_in(nvm_we),
        .waddr_in(c_q.idx),
        .wdata_in(reg_rdata),
        .raddr_in(rd_addr),
        .rdata_out(nvm_rdata)
    );

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_out = l_q.oe;
    assign nvm_busy_out = c_q.busy;

endmodule : cps_top

// ---- cps_pkg.sv ----
// Shared constants and carriers for the serial configuration port.
// Assumes one core clock domain and one link-sampling clock domain.
package cps_pkg;

    // Target address and command codes in the low two command bits
    localparam logic [6:0] CPS_TARGET_ADDR = 7'h6a;
    localparam logic [1:0] CPS_CMD_WRITE = 2'h0;
    localparam logic [1:0] CPS_CMD_SAVE = 2'h1;
    localparam logic [1:0] CPS_CMD_RESTORE = 2'h2;

    // Identifier byte; value is arbitrary
    localparam logic [7:0] CPS_ID_DEFAULT = 8'h5a;

    // Widths, counts and synchroniser depths
    localparam int CPS_AW = 8;
    localparam int CPS_DW = 8;
    localparam int CPS_PIN_STAGES = 3;
    localparam int CPS_HS_STAGES = 2;
    localparam logic [3:0] CPS_BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] CPS_LAST_INDEX = 8'hff;

    typedef enum logic [1:0] {
        CPS_OP_WRITE = 2'h0,
        CPS_OP_READ = 2'h1,
        CPS_OP_SAVE = 2'h2,
        CPS_OP_RESTORE = 2'h3
    } cps_op_t;

    typedef struct packed {
        cps_op_t op;
        logic [7:0] addr;
        logic [7:0] data;
    } cps_req_t;

    typedef enum logic [5:0] {
        CPS_LS_IDLE = 6'h01,
        CPS_LS_RX = 6'h02,
        CPS_LS_ACK = 6'h04,
        CPS_LS_TX = 6'h08,
        CPS_LS_TXACK = 6'h10,
        CPS_LS_TXNEXT = 6'h20
    } cps_lstate_t;

    typedef enum logic [4:0] {
        CPS_PH_ADDR = 5'h01,
        CPS_PH_CMD = 5'h02,
        CPS_PH_REG = 5'h04,
        CPS_PH_DATA = 5'h08,
        CPS_PH_XTRA = 5'h10
    } cps_phase_t;

    typedef enum logic [2:0] {
        CPS_CS_IDLE = 3'h1,
        CPS_CS_READ = 3'h2,
        CPS_CS_COPY = 3'h4
    } cps_cstate_t;

    typedef struct packed {
        logic scl_f;
        logic sda_f;
        cps_lstate_t st;
        cps_phase_t ph;
        logic [7:0] sh;
        logic [3:0] bitc;
        logic rd;
        logic [7:0] ptr;
        logic [7:0] txb;
        logic [7:0] rbuf;
        logic oe;
        logic nvm_pend;
        logic nvm_save;
        cps_req_t req;
        logic req_tgl;
        logic ack_old;
    } cps_link_t;

    typedef struct packed {
        cps_cstate_t st;
        logic req_old;
        logic ack_tgl;
        logic [7:0] rdata;
        logic [7:0] idx;
        logic half;
        logic save;
        logic busy;
        logic from_req;
    } cps_core_t;

endpackage : cps_pkg

// ---- cps_sync.sv ----
// Chain of flip-flops bringing a level into the local clock domain.
// Assumes the input is stable for several local clock periods.
`timescale 1ns/1ps
module cps_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Level in and out
    input wire logic d_in,
    output logic q_out,
    output logic prev_out
);
    typedef struct packed {
        logic [STAGES-1:0] chain;
    } cps_sync_state_t;

    cps_sync_state_t s_q;
    cps_sync_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.chain = {s_q.chain[STAGES-2:0], d_in};
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            // Ones match the idle-high bus pins, so the pin chains give no false edge after reset
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // Only meaningful with three or more stages; first flop stays private
    assign q_out = s_q.chain[STAGES-1];
    assign prev_out = s_q.chain[STAGES-2];

endmodule : cps_sync

// ---- cps_mem.sv ----
// Small byte memory with one write port and a registered read port.
// Assumes contents are undefined until written.
`timescale 1ns/1ps
module cps_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Write port
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [DW-1:0] wdata_in,
    // Read port
    input wire logic [AW-1:0] raddr_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    // Array kept out of reset so it maps onto plain RAM
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem_q[raddr_in];
        end
    end

    assign rdata_out = rdata_q;

endmodule : cps_mem

// ---- cps_top_asserts.sv ----
// Checker for the serial pins and the copy status of cps_top.
// Assumes the bench SCL is slow against link_clk_in.
`timescale 1ns/1ps
module cps_top_asserts
    import cps_pkg::*;
(
    // Clocks and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic link_clk_in,
    // Watched pins and status
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic nvm_busy_out
);
    // Copy length counter; ten bits cover one full copy
    logic [9:0] busy_cnt_q;
    logic [9:0] busy_cnt_d;
    always_comb busy_cnt_d = nvm_busy_out ? busy_cnt_q + 10'h001 : 10'h000;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) busy_cnt_q <= 10'h000;
        else busy_cnt_q <= busy_cnt_d;
    end
    property p_od_zero;
        @(posedge clk_in) disable iff (reset_in) sda_out == 1'b0;
    endproperty
    a_od_zero: assert property (p_od_zero) else $error("sda_out not low");
    property p_ack_scl_low;
        @(posedge link_clk_in) disable iff (reset_in) $rose(sda_oe_out) |-> !scl_in;
    endproperty
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("drive began, scl high");
    property p_oe_stands;
        @(posedge link_clk_in) disable iff (reset_in) $rose(sda_oe_out) |-> sda_oe_out[*8];
    endproperty
    a_oe_stands: assert property (p_oe_stands) else $error("drive too short");
    property p_oe_scl_high;
        @(posedge link_clk_in) disable iff (reset_in)
            scl_in && $past(scl_in) |-> $stable(sda_oe_out);
    endproperty
    a_oe_scl_high: assert property (p_oe_scl_high) else $error("sda moved, scl high");
    property p_busy_quiet;
        @(posedge clk_in) disable iff (reset_in) nvm_busy_out |-> !sda_oe_out;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
    property p_boot_busy;
        @(posedge clk_in) disable iff (reset_in) $fell(reset_in) |-> nvm_busy_out;
    endproperty
    a_boot_busy: assert property (p_boot_busy) else $error("no boot restore");
    property p_copy_len;
        @(posedge clk_in) disable iff (reset_in)
            $fell(nvm_busy_out) |-> busy_cnt_q >= 10'h1f9 && busy_cnt_q <= 10'h208;
    endproperty
    a_copy_len: assert property (p_copy_len) else $error("copy length wrong");
    property p_busy_hold;
        @(posedge clk_in) disable iff (reset_in) $rose(nvm_busy_out) |=> nvm_busy_out[*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy glitch");
endmodule : cps_top_asserts
bind cps_top cps_top_asserts chk_u (.clk_in(clk_in), .reset_in(reset_in),
    .link_clk_in(link_clk_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .nvm_busy_out(nvm_busy_out));

// ---- cps_host_model.sv ----
// Bus controller model: makes SCL and pulls SDA low.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/1ps
module cps_host_model #(
    parameter int HALF_NS = 400
) (
    // Resolved data line
    input wire logic sda_in,
    // Driven lines
    output logic scl_out,
    output logic sda_pull_out
);
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    // Start or repeated start; raises SCL first, since a frame ended without a stop leaves it low
    task automatic start_cond();
        sda_pull_out = 1'b0;
        #(HALF_NS / 2);
        scl_out = 1'b1;
        #(HALF_NS);
        sda_pull_out = 1'b1;
        #(HALF_NS);
        scl_out = 1'b0;
        #(HALF_NS / 2);
    endtask : start_cond
    task automatic stop_cond();
        sda_pull_out = 1'b1;
        #(HALF_NS / 2);
        scl_out = 1'b1;
        #(HALF_NS);
        sda_pull_out = 1'b0;
        #(HALF_NS);
    endtask : stop_cond
    // Data set mid-low, so the target filter delay is covered
    task automatic bit_xfer(input logic b, output logic s);
        sda_pull_out = !b;
        #(HALF_NS / 2);
        scl_out = 1'b1;
        #(HALF_NS / 2);
        s = sda_in;
        #(HALF_NS / 2);
        scl_out = 1'b0;
        #(HALF_NS / 2);
    endtask : bit_xfer
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = !s;
    endtask : put_byte
    // Acks all but the last byte
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(last, s);
    endtask : get_byte
endmodule : cps_host_model

// ---- cps_top_tb_top.sv ----
// Bench for the serial configuration port with a controller model.
// Assumes the checker is bound into cps_top.
`timescale 1ns/1ps
module cps_top_tb_top
    import cps_pkg::*;
;
    logic clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic scl_w;
    logic sda_w;
    logic host_pull;
    logic sda_o;
    logic sda_oe;
    logic busy;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam logic [7:0] ADDR_W = {CPS_TARGET_ADDR, 1'b0};
    localparam logic [7:0] ADDR_R = {CPS_TARGET_ADDR, 1'b1};
    assign sda_w = !(host_pull || sda_oe);
    initial forever #4 clk_in = !clk_in;
    initial begin
        #5;
        forever #24 link_clk_in = !link_clk_in;
    end
    cps_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
        .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .nvm_busy_out(busy));
    cps_host_model host_u (.sda_in(sda_w), .scl_out(scl_w), .sda_pull_out(host_pull));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            final_report();
        end
    end
    // Acks come back one bit per byte sent
    task automatic wr(input logic [7:0] q[$], input logic stop, output logic [7:0] acks);
        acks = 8'h00;
        host_u.start_cond();
        foreach (q[i]) begin
            host_u.put_byte(q[i], acks[i]);
        end
        if (stop) begin
            host_u.stop_cond();
        end
    endtask : wr
    task automatic rd(input logic [7:0] exp[$]);
        logic a;
        logic [7:0] v;
        host_u.start_cond();
        host_u.put_byte(ADDR_R, a);
        check("read ack", {7'h00, a}, 8'h01);
        host_u.get_byte(1'b0, v);
        check("leading id", v, CPS_ID_DEFAULT);
        foreach (exp[i]) begin
            host_u.get_byte(i == exp.size() - 1, v);
            check("read data", v, exp[i]);
        end
        host_u.stop_cond();
    endtask : rd
    task automatic poll();
        logic [7:0] k;
        for (int n = 0; n < 8; n++) begin
            wr('{ADDR_W}, 1'b1, k);
            if (k[0] === 1'b1) break;
        end
        check("poll ack", k, 8'h01);
    endtask : poll
    task automatic t_boot();
        check("boot busy", {7'h00, busy}, 8'h01);
        poll();
    endtask : t_boot
    // Burst wraps the pointer past the top register
    task automatic t_burst();
        logic [7:0] k;
        wr('{ADDR_W, 8'hfc, 8'hfe, 8'ha1, 8'hb2, 8'hc3}, 1'b1, k);
        check("write acks", k, 8'h3f);
        wr('{ADDR_W, 8'h00, 8'hfe}, 1'b0, k);
        check("pointer acks", k, 8'h07);
        rd('{8'ha1, 8'hb2, 8'hc3});
    endtask : t_burst
    task automatic t_foreign();
        logic [7:0] k;
        wr('{8'hd6, 8'h00, 8'hfe, 8'h55}, 1'b1, k);
        check("foreign acks", k, 8'h00);
    endtask : t_foreign
    // A foreign write would be saved and show after restore
    task automatic t_save();
        logic [7:0] k;
        wr('{ADDR_W, 8'hfd}, 1'b0, k);
        check("save acks", k, 8'h03);
        check("busy before stop", {7'h00, busy}, 8'h00);
        host_u.stop_cond();
        check("busy after stop", {7'h00, busy}, 8'h01);
        poll();
        wr('{ADDR_W, 8'h00, 8'hfe, 8'h77}, 1'b1, k);
        check("overwrite acks", k, 8'h0f);
        wr('{ADDR_W, 8'hfa}, 1'b1, k);
        check("restore acks", k, 8'h03);
        poll();
        wr('{ADDR_W, 8'h00, 8'hfe}, 1'b0, k);
        rd('{8'ha1});
    endtask : t_save
    task automatic t_nop();
        logic [7:0] k;
        wr('{ADDR_W, 8'h03}, 1'b1, k);
        check("nop acks", k, 8'h03);
        wr('{ADDR_W, 8'h01, 8'hfe}, 1'b1, k);
        check("long save acks", k, 8'h03);
        repeat (20) @(negedge clk_in);
        check("no copy", {7'h00, busy}, 8'h00);
    endtask : t_nop
    // Repeated start cuts a command byte in half
    task automatic t_abort();
        logic a;
        logic [7:0] k;
        host_u.start_cond();
        host_u.put_byte(ADDR_W, a);
        repeat (4) host_u.bit_xfer(1'b0, a);
        wr('{ADDR_W, 8'h00, 8'hfe}, 1'b0, k);
        check("after abort acks", k, 8'h07);
        rd('{8'ha1});
    endtask : t_abort
    initial begin
        repeat (16) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (2) @(negedge clk_in);
        t_boot();
        t_burst();
        t_foreign();
        t_save();
        t_nop();
        t_abort();
        final_report();
    end
endmodule : cps_top_tb_top
